// ### common/rpas_consts.vh
`ifndef RPAS_CONSTS_VH
`define RPAS_CONSTS_VH
// page-selection register
`define RPAS_PAGE_SELECT_OFS      3'h0
`define RPAS_PAGE_SELECT_RST      8'h80
`define RPAS_PAGE_MODE_BIT        7
`define RPAS_PAGE_NUM_MSB         2
`define RPAS_PAGE_NUM_LSB         0
`define RPAS_PAGE_RSVD_MASK       8'h87
`define RPAS_PAGE_MODE_RST        1'h1
`define RPAS_PAGE_RSVD_RST        4'h0
`define RPAS_PAGE_NUM_RST         3'h0
`define RPAS_PAGE_RSVD_MSB        6
`define RPAS_PAGE_RSVD_LSB        3
// register address layout
`define RPAS_ADDR_W               6
`define RPAS_LOW_W                3
`define RPAS_LATCH_RST            6'h00
`define RPAS_RD_IDLE              8'h00
// first address of each page, every one a mirror of the page register
`define RPAS_PAGE_MIRROR0         6'h00
`define RPAS_PAGE_MIRROR1         6'h08
`define RPAS_PAGE_MIRROR2         6'h10
`define RPAS_PAGE_MIRROR3         6'h18
`define RPAS_PAGE_MIRROR4         6'h20
`define RPAS_PAGE_MIRROR5         6'h28
`define RPAS_PAGE_MIRROR6         6'h30
`define RPAS_PAGE_MIRROR7         6'h38
`endif

// ### logic/rpas_page_select.v
// Function
// - page mode set puts page number onto register address bits five to three.
// - page mode set takes low address bits from pins or latch, per interface style.
// - page mode clear uses the full latched address, page number ignored.
// - page register decoded at first address of every page, one shared storage.
// - reset loads page register with 80h: page mode on, page zero.
`timescale 1ns/1ps
`include "rpas_consts.vh"

module rpas_page_select (
   input  wire       i_clk,
   input  wire       i_rst,
   input  wire       i_mux_bus,
   input  wire       i_ale,
   input  wire [5:0] i_addr_pins,
   input  wire [7:0] i_data_bus,
   input  wire       i_wr,
   input  wire       i_rd,
   output wire [5:0] o_reg_addr,
   output wire       o_page_hit,
   output reg  [7:0] o_rd_data,
   output wire       o_page_mode_enable,
   output wire [2:0] o_page_number
);

   // widths of the register map
   localparam ADDR_W = `RPAS_ADDR_W;
   localparam LOW_W  = `RPAS_LOW_W;
   localparam PAGE_W = `RPAS_ADDR_W - `RPAS_LOW_W;
   localparam RSVD_W = `RPAS_PAGE_RSVD_MSB - `RPAS_PAGE_RSVD_LSB + 1;
   localparam DATA_W = 8;

   // page register, kept as its three fields
   reg               page_mode_q;
   reg               page_mode_d;
   reg  [RSVD_W-1:0] page_rsvd_q;
   reg  [RSVD_W-1:0] page_rsvd_d;
   reg  [PAGE_W-1:0] page_num_q;
   reg  [PAGE_W-1:0] page_num_d;

   // internal address latch, loaded from the multiplexed bus
   reg  [ADDR_W-1:0] latch_q;
   reg  [ADDR_W-1:0] latch_d;

   // next read data; o_rd_data is its flip-flop
   reg  [DATA_W-1:0] rd_data_d;

   // address pins five to three play no part here: in page mode the page number
   // stands in their place, and with page mode off the latch gives the whole address
   wire [LOW_W-1:0]  low_bits;
   wire [ADDR_W-1:0] addr_w;
   wire              hit_w;
   wire              wr_hit;
   wire              rd_hit;
   wire [DATA_W-1:0] page_byte_w;

   // one shared register answers at the first address of every page;
   // with page mode off a mirror is any latched address that is a multiple of eight
   function mirror_hit;
      input [5:0] addr;
      begin
         if (addr == `RPAS_PAGE_MIRROR0) begin
            mirror_hit = 1'h1;
         end else if (addr == `RPAS_PAGE_MIRROR1) begin
            mirror_hit = 1'h1;
         end else if (addr == `RPAS_PAGE_MIRROR2) begin
            mirror_hit = 1'h1;
         end else if (addr == `RPAS_PAGE_MIRROR3) begin
            mirror_hit = 1'h1;
         end else if (addr == `RPAS_PAGE_MIRROR4) begin
            mirror_hit = 1'h1;
         end else if (addr == `RPAS_PAGE_MIRROR5) begin
            mirror_hit = 1'h1;
         end else if (addr == `RPAS_PAGE_MIRROR6) begin
            mirror_hit = 1'h1;
         end else if (addr == `RPAS_PAGE_MIRROR7) begin
            mirror_hit = 1'h1;
         end else begin
            mirror_hit = 1'h0;
         end
      end
   endfunction

   // low register address bits for the active interface style
   function [2:0] low_select;
      input       mux_style;
      input [2:0] latched;
      input [2:0] pins;
      begin
         if (mux_style) begin
            low_select = latched;
         end else begin
            low_select = pins;
         end
      end
   endfunction

   // with page mode off the pins play no part; the latch must have been loaded first
   function [5:0] form_addr;
      input       page_mode;
      input [2:0] page_num;
      input [2:0] low;
      input [5:0] latched;
      begin
         if (page_mode) begin
            form_addr = {page_num, low};
         end else begin
            form_addr = latched;
         end
      end
   endfunction

   // byte image of the page register as the host reads it
   function [7:0] page_image;
      input       mode;
      input [3:0] rsvd;
      input [2:0] num;
      begin
         page_image = {mode, rsvd, num};
      end
   endfunction

   // low bits follow the interface style, upper bits come from the page number in page mode
   assign low_bits    = low_select(i_mux_bus, latch_q[LOW_W-1:0], i_addr_pins[LOW_W-1:0]);
   assign addr_w      = form_addr(page_mode_q, page_num_q, low_bits, latch_q);
   assign hit_w       = mirror_hit(addr_w);
   assign wr_hit      = i_wr & hit_w;
   assign rd_hit      = i_rd & hit_w;
   assign page_byte_w = page_image(page_mode_q, page_rsvd_q, page_num_q);

   // the latch holds its address until the next address phase
   always @* begin
      latch_d = latch_q;
      if (i_ale) begin
         latch_d = i_data_bus[ADDR_W-1:0];
      end
   end

   // all eight mirrors write the same fields, so a page switch from any page lands here;
   // reserved bits are kept as written, so software that keeps them zero reads zero back
   always @* begin
      page_mode_d = page_mode_q;
      page_rsvd_d = page_rsvd_q;
      page_num_d  = page_num_q;
      if (wr_hit) begin
         page_mode_d = i_data_bus[`RPAS_PAGE_MODE_BIT];
         page_rsvd_d = i_data_bus[`RPAS_PAGE_RSVD_MSB:`RPAS_PAGE_RSVD_LSB];
         page_num_d  = i_data_bus[`RPAS_PAGE_NUM_MSB:`RPAS_PAGE_NUM_LSB];
      end
   end

   // read data drops back to idle when the strobe goes, so a stale byte is never seen twice
   always @* begin
      rd_data_d = `RPAS_RD_IDLE;
      if (rd_hit) begin
         rd_data_d = page_byte_w;
      end
   end

   // address latch
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         latch_q <= `RPAS_LATCH_RST;
      end else begin
         latch_q <= latch_d;
      end
   end

   // reset lands in page mode on page zero, so the first access reaches page zero at once
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         page_mode_q <= `RPAS_PAGE_MODE_RST;
      end else begin
         page_mode_q <= page_mode_d;
      end
   end

   // reserved field
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         page_rsvd_q <= `RPAS_PAGE_RSVD_RST;
      end else begin
         page_rsvd_q <= page_rsvd_d;
      end
   end

   // page number
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         page_num_q <= `RPAS_PAGE_NUM_RST;
      end else begin
         page_num_q <= page_num_d;
      end
   end

   // read data stands for the one cycle after the read strobe
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_rd_data <= `RPAS_RD_IDLE;
      end else begin
         o_rd_data <= rd_data_d;
      end
   end

   // outputs
   assign o_reg_addr         = addr_w;
   assign o_page_hit         = hit_w;
   assign o_page_mode_enable = page_mode_q;
   assign o_page_number      = page_num_q;

endmodule // rpas_page_select

// ### verification/rpas_asserts.sv
`timescale 1ns/1ps
module rpas_chk (
   input wire       i_clk,
   input wire       i_rst,
   input wire       i_mux_bus,
   input wire       i_ale,
   input wire       i_wr,
   input wire       i_rd,
   input wire [5:0] i_addr_pins,
   input wire [7:0] i_data_bus,
   input wire [5:0] o_reg_addr,
   input wire       o_page_hit,
   input wire [7:0] o_rd_data,
   input wire       o_page_mode_enable,
   input wire [2:0] o_page_number
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);

   sequence s_addr_latched;
      i_ale ##1 !i_ale;
   endsequence

   sequence s_page_write;
      i_wr && o_page_hit;
   endsequence

   sequence s_page_read;
      i_rd && o_page_hit;
   endsequence

   page_hi_a: assert property (o_page_mode_enable|->o_reg_addr[5:3]==o_page_number) else $error("page bits");
   pin_lo_a: assert property (o_page_mode_enable&&!i_mux_bus|->o_reg_addr[2:0]==i_addr_pins[2:0]) else $error("low");
   latch_lo_a: assert property (s_addr_latched ##0 (o_page_mode_enable && i_mux_bus) |->
      o_reg_addr[2:0] == $past(i_data_bus[2:0])) else $error("latched low bits");
   latch_full_a: assert property (s_addr_latched ##0 !o_page_mode_enable |->
      o_reg_addr == $past(i_data_bus[5:0])) else $error("latched address");
   mirror_dec_a: assert property (o_page_hit == (o_reg_addr[2:0] == 3'h0)) else $error("mirror decode");
   page_wr_a: assert property (s_page_write |=> o_page_mode_enable == $past(i_data_bus[7]) &&
      o_page_number == $past(i_data_bus[2:0])) else $error("page write");
   page_rd_a: assert property (s_page_read |=> o_rd_data[7] == $past(o_page_mode_enable) &&
      o_rd_data[2:0] == $past(o_page_number)) else $error("page read");
   rst_val_a: assert property (disable iff (1'b0) i_rst |=> o_page_mode_enable &&
      o_page_number == 3'h0 && o_rd_data == 8'h00) else $error("reset value");
endmodule // rpas_chk
bind rpas_page_select rpas_chk u_chk(.*);

// ### verification/rpas_page_select_tb.sv
`timescale 1ns/1ps
module rpas_page_select_tb;
   reg        i_clk = 1'b0;
   reg        i_rst = 1'b1;
   reg        i_mux_bus = 1'b1;
   reg        i_ale = 1'b0;
   reg        i_wr = 1'b0;
   reg        i_rd = 1'b0;
   reg  [5:0] i_addr_pins = 6'h00;
   reg  [7:0] i_data_bus = 8'h00;
   wire [5:0] o_reg_addr;
   wire       o_page_hit;
   wire [7:0] o_rd_data;
   wire       o_page_mode_enable;
   wire [2:0] o_page_number;
   integer    err_total = 0;
   integer    samples_checked = 0;

   always #50 i_clk = ~i_clk;

   rpas_page_select i_dut (
      .i_clk              (i_clk),
      .i_rst              (i_rst),
      .i_mux_bus          (i_mux_bus),
      .i_ale              (i_ale),
      .i_addr_pins        (i_addr_pins),
      .i_data_bus         (i_data_bus),
      .i_wr               (i_wr),
      .i_rd               (i_rd),
      .o_reg_addr         (o_reg_addr),
      .o_page_hit         (o_page_hit),
      .o_rd_data          (o_rd_data),
      .o_page_mode_enable (o_page_mode_enable),
      .o_page_number      (o_page_number)
   );

   task chk;
      input [7:0] got;
      input [7:0] exp;
      begin
         samples_checked = samples_checked + 1;
         if (got !== exp) begin
            err_total = err_total + 1;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask

   // one host access: address phase on the multiplexed bus, then a data phase with a strobe
   task acc;
      input [5:0] a;
      input [7:0] d;
      input       w;
      begin
         @(posedge i_clk);
         #1;
         i_ale = 1'b1;
         i_data_bus = {2'h0, a};
         @(posedge i_clk);
         #1;
         i_ale = 1'b0;
         i_data_bus = d;
         i_wr = w;
         i_rd = !w;
         @(posedge i_clk);
         #1;
         i_wr = 1'b0;
         i_rd = 1'b0;
      end
   endtask

   task wrap_up;
      begin
         $display("checks %0d errors %0d", samples_checked, err_total);
         if (err_total == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
         end else begin
            $display("TEST FAILED");
         end
         $finish;
      end
   endtask

   initial begin
      repeat (5) @(posedge i_clk);
      #1;
      i_rst = 1'b0;
      acc(6'h00, 8'h00, 1'b0);
      chk(o_rd_data, 8'h80);
      chk({7'h00, o_page_mode_enable}, 8'h01);
      $display("test reset_value done");
      acc(6'h00, 8'h83, 1'b1);
      acc(6'h00, 8'h00, 1'b0);
      chk(o_rd_data, 8'h83);
      chk({5'h00, o_page_number}, 8'h03);
      chk({2'h0, o_reg_addr}, 8'h18);
      chk({7'h00, o_page_hit}, 8'h01);
      $display("test page_switch done");
      acc(6'h00, 8'h00, 1'b1);
      acc(6'h2A, 8'h00, 1'b0);
      chk({2'h0, o_reg_addr}, 8'h2A);
      chk(o_rd_data, 8'h00);
      chk({7'h00, o_page_hit}, 8'h00);
      acc(6'h08, 8'h85, 1'b1);
      chk({7'h00, o_page_mode_enable}, 8'h01);
      chk({5'h00, o_page_number}, 8'h05);
      $display("test page_mode_off done");
      i_mux_bus = 1'b0;
      i_addr_pins = 6'h3B;
      #1;
      chk({2'h0, o_reg_addr}, 8'h2B);
      @(posedge i_clk);
      #1;
      i_addr_pins = 6'h00;
      acc(6'h07, 8'h00, 1'b0);
      chk(o_rd_data, 8'h85);
      chk({2'h0, o_reg_addr}, 8'h28);
      $display("test separate_pins done");
      @(posedge i_clk);
      #1;
      i_rst = 1'b1;
      @(posedge i_clk);
      #1;
      chk({7'h00, o_page_mode_enable}, 8'h01);
      chk({5'h00, o_page_number}, 8'h00);
      i_rst = 1'b0;
      acc(6'h00, 8'h00, 1'b0);
      chk(o_rd_data, 8'h80);
      $display("test mid_reset done");
      wrap_up;
   end
endmodule // rpas_page_select_tb
